//--- hdl/cmc_comparator_ctrl.sv
// comparator input select, mode decode, sampling filter and edge flags with axi4-lite registers
// Function
// - plus select field bits 5..3 routes input 0..7 to non-inverting input
// - minus select field routes input 0..7 to inverting input
// - equal plus and minus selections force the comparator into shut-down
// - software writes zero to mux bit 7; bit 6 always reads zero
// - raw result high when plus exceeds minus; inverted when invert bit is set
// - rise and fall enable bits choose which edges request an interrupt
// - fall flag sets on falling output edge, rise flag on rising edge
// - read-only status bit shows current output after optional filtering
// - enable bit zero disables the block whatever the other settings
// - enabled, window and sample clear, count or period zero gives continuous mode
// - enabled, count one and nonzero period gives sampled non-filtered mode
// - enabled, count above one and nonzero period gives sampled filtered mode
// - the filter runs only from the internal bus clock
// - output changes after programmed number of agreeing samples; one means plain sampler
// - sample bit clear with zero count resets the filter state
// - period gives sample interval in bus clocks; zero disables the filter
// - edge flags stay set until software writes one to them
// - filtered output starts at zero, changes after count consecutive new samples
// - interrupt request asserts while a flag and its enable are both set
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
module cmc_comparator_ctrl (
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst_b,
  input  wire logic [cmc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                      i_s_axi_awvalid,
  output logic                           o_s_axi_awready,
  input  wire logic [31:0]               i_s_axi_wdata,
  input  wire logic [3:0]                i_s_axi_wstrb,
  input  wire logic                      i_s_axi_wvalid,
  output logic                           o_s_axi_wready,
  output logic [1:0]                     o_s_axi_bresp,
  output logic                           o_s_axi_bvalid,
  input  wire logic                      i_s_axi_bready,
  input  wire logic [cmc_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                      i_s_axi_arvalid,
  output logic                           o_s_axi_arready,
  output logic [31:0]                    o_s_axi_rdata,
  output logic [1:0]                     o_s_axi_rresp,
  output logic                           o_s_axi_rvalid,
  input  wire logic                      i_s_axi_rready,
  input  wire logic                      i_comparator_raw,
  output logic [cmc_pkg::SEL_W-1:0]      o_noninverting_input,
  output logic [cmc_pkg::SEL_W-1:0]      o_inverting_input,
  output logic                           o_comparator_power,
  output logic                           o_comparator_result,
  output logic                           o_irq_req
);
  // software state
  logic [cmc_pkg::CNT_W-1:0] agree_sample_count;
  logic [cmc_pkg::PER_W-1:0] sample_period;
  logic                      enable;
  logic                      output_invert;
  logic                      sample_enable;
  logic                      window_enable;
  logic                      rise_irq_enable;
  logic                      fall_irq_enable;
  logic                      rise_edge_flag;
  logic                      fall_edge_flag;
  logic [cmc_pkg::SEL_W-1:0] plus_input_select;
  logic [cmc_pkg::SEL_W-1:0] minus_input_select;
  logic                      mux_reserved7;
  // bus state
  logic [5:0]  aw_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_held;
  logic        w_held;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic [5:0]  rd_idx;
  // datapath state
  logic                      sync_a;
  logic                      sync_b;
  logic [cmc_pkg::PER_W-1:0] div_cnt;
  logic [cmc_pkg::CNT_W-1:0] agree_cnt;
  logic                      filt_out;
  logic                      filtered_output_status;
  logic                      status_prev;
  wire cmp_active = enable && (plus_input_select != minus_input_select);
  wire side_bits_clear = !window_enable && !sample_enable;
  cmc_pkg::cmc_mode_type mode;
  always_comb begin
    if (!cmp_active) begin
      mode = cmc_pkg::MODE_DISABLED;
    end else if (!side_bits_clear) begin
      mode = cmc_pkg::MODE_ILLEGAL;
    end else if (agree_sample_count == '0 || sample_period == '0) begin
      mode = cmc_pkg::MODE_CONTINUOUS;
    end else if (agree_sample_count == cmc_pkg::CNT_ONE) begin
      mode = cmc_pkg::MODE_SAMPLED;
    end else begin
      mode = cmc_pkg::MODE_FILTERED;
    end
  end
  assign o_noninverting_input = plus_input_select;
  assign o_inverting_input    = minus_input_select;
  assign o_comparator_power   = cmp_active;

  // raw result is unclocked; synchronise before any use
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= i_comparator_raw;
      sync_b <= sync_a;
    end
  end
  // powered-down core reads as zero before the invert
  wire result_pre = (cmp_active && sync_b) ^ output_invert;
  wire sampling     = (mode == cmc_pkg::MODE_SAMPLED) || (mode == cmc_pkg::MODE_FILTERED);
  wire filter_reset = !sampling;
  wire sample_tick  = sampling && (div_cnt >= sample_period - cmc_pkg::PER_ONE);
  wire [cmc_pkg::PER_W-1:0] next_div_cnt = sample_tick ? '0 : div_cnt + cmc_pkg::PER_ONE;
  wire [cmc_pkg::CNT_W-1:0] next_agree   = agree_cnt + cmc_pkg::CNT_ONE;
  wire agree_done = next_agree >= agree_sample_count;

  // divider and agreement counter run only on the bus clock
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || filter_reset) begin
      div_cnt   <= '0;
      agree_cnt <= '0;
      filt_out  <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      if (sample_tick) begin
        if (result_pre == filt_out) begin
          agree_cnt <= '0;
        end else if (agree_done) begin
          filt_out  <= result_pre;
          agree_cnt <= '0;
        end else begin
          agree_cnt <= next_agree;
        end
      end
    end
  end
  wire next_status = sampling ? filt_out : result_pre;
  wire rise_edge = filtered_output_status && !status_prev;
  wire fall_edge = !filtered_output_status && status_prev;
  wire wr_fire   = aw_held && w_held && !bvalid;
  wire wr_hit    = wr_fire && w_strb[0];
  wire wr_status = wr_hit && (aw_idx == cmc_pkg::IDX_STATUS);
  wire clr_rise  = wr_status && w_data[cmc_pkg::BIT_RISE_FLAG];
  wire clr_fall  = wr_status && w_data[cmc_pkg::BIT_FALL_FLAG];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      filtered_output_status <= 1'b0;
      status_prev            <= 1'b0;
      rise_edge_flag         <= 1'b0;
      fall_edge_flag         <= 1'b0;
    end else begin
      filtered_output_status <= next_status;
      status_prev            <= filtered_output_status;
      // a new edge wins over a clear in the same cycle
      rise_edge_flag <= rise_edge || (rise_edge_flag && !clr_rise);
      fall_edge_flag <= fall_edge || (fall_edge_flag && !clr_fall);
    end
  end

  assign o_comparator_result = filtered_output_status;
  assign o_irq_req = (rise_edge_flag && rise_irq_enable)
                  || (fall_edge_flag && fall_irq_enable);
  wire aw_take = i_s_axi_awvalid && o_s_axi_awready;
  wire w_take  = i_s_axi_wvalid && o_s_axi_wready;
  wire wr_mapped = (aw_idx <= cmc_pkg::IDX_STATUS) || (aw_idx == cmc_pkg::IDX_MUX);
  assign o_s_axi_awready = !aw_held && !bvalid;
  assign o_s_axi_wready  = !w_held && !bvalid;
  assign o_s_axi_bvalid  = bvalid;
  assign o_s_axi_bresp   = bresp;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= cmc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_idx  <= i_s_axi_awaddr[cmc_pkg::ADDR_W-1:2];
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_mapped ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
      end else if (bvalid && i_s_axi_bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      agree_sample_count <= cmc_pkg::RST_COUNT;
      sample_period      <= cmc_pkg::RST_PERIOD;
      enable             <= 1'b0;
      output_invert      <= 1'b0;
      sample_enable      <= 1'b0;
      window_enable      <= 1'b0;
      rise_irq_enable    <= 1'b0;
      fall_irq_enable    <= 1'b0;
      plus_input_select  <= cmc_pkg::RST_MUX[cmc_pkg::PLUS_LSB +: cmc_pkg::SEL_W];
      minus_input_select <= cmc_pkg::RST_MUX[cmc_pkg::MINUS_LSB +: cmc_pkg::SEL_W];
      mux_reserved7      <= 1'b0;
    end else if (wr_hit) begin
      unique case (aw_idx)
        cmc_pkg::IDX_CTRL_COUNT: agree_sample_count <= w_data[cmc_pkg::CNT_W-1:0];
        cmc_pkg::IDX_PERIOD:     sample_period <= w_data[cmc_pkg::PER_W-1:0];
        cmc_pkg::IDX_CTRL_MODE: begin
          enable        <= w_data[cmc_pkg::BIT_ENABLE];
          output_invert <= w_data[cmc_pkg::BIT_INVERT];
          sample_enable <= w_data[cmc_pkg::BIT_SAMPLE];
          window_enable <= w_data[cmc_pkg::BIT_WINDOW];
        end
        cmc_pkg::IDX_STATUS: begin
          rise_irq_enable <= w_data[cmc_pkg::BIT_RISE_IE];
          fall_irq_enable <= w_data[cmc_pkg::BIT_FALL_IE];
        end
        cmc_pkg::IDX_MUX: begin
          plus_input_select  <= w_data[cmc_pkg::PLUS_LSB +: cmc_pkg::SEL_W];
          minus_input_select <= w_data[cmc_pkg::MINUS_LSB +: cmc_pkg::SEL_W];
          mux_reserved7      <= w_data[cmc_pkg::BIT_MUX_RSV7];
        end
        default: ;
      endcase
    end
  end
  wire [5:0] ar_idx = i_s_axi_araddr[cmc_pkg::ADDR_W-1:2];
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (ar_idx)
      cmc_pkg::IDX_CTRL_COUNT: rd_word[cmc_pkg::CNT_W-1:0] = agree_sample_count;
      cmc_pkg::IDX_PERIOD:     rd_word[cmc_pkg::PER_W-1:0] = sample_period;
      cmc_pkg::IDX_CTRL_MODE: begin
        rd_word[cmc_pkg::BIT_ENABLE] = enable;
        rd_word[cmc_pkg::BIT_INVERT] = output_invert;
        rd_word[cmc_pkg::BIT_SAMPLE] = sample_enable;
        rd_word[cmc_pkg::BIT_WINDOW] = window_enable;
      end
      cmc_pkg::IDX_STATUS: begin
        rd_word[cmc_pkg::BIT_FILTERED_OUTPUT_STATUS]      = filtered_output_status;
        rd_word[cmc_pkg::BIT_FALL_FLAG] = fall_edge_flag;
        rd_word[cmc_pkg::BIT_RISE_FLAG] = rise_edge_flag;
        rd_word[cmc_pkg::BIT_FALL_IE]   = fall_irq_enable;
        rd_word[cmc_pkg::BIT_RISE_IE]   = rise_irq_enable;
      end
      cmc_pkg::IDX_MUX: begin
        rd_word[cmc_pkg::PLUS_LSB +: cmc_pkg::SEL_W]  = plus_input_select;
        rd_word[cmc_pkg::MINUS_LSB +: cmc_pkg::SEL_W] = minus_input_select;
        rd_word[cmc_pkg::BIT_MUX_RSV7] = mux_reserved7;
        rd_word[cmc_pkg::BIT_MUX_RSV6] = 1'b0;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  assign o_s_axi_arready = !rvalid;
  assign o_s_axi_rvalid  = rvalid;
  assign o_s_axi_rdata   = rdata;
  assign o_s_axi_rresp   = rresp;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= cmc_pkg::RESP_OKAY;
      rd_idx <= '0;
    end else if (i_s_axi_arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_ok ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
      rd_idx <= ar_idx;
    end else if (rvalid && i_s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  chk_same_select_off: assert property (
    (plus_input_select == minus_input_select) |-> !o_comparator_power)
    else $error("comparator powered with equal selections");
  chk_mux_bit6_zero: assert property (
    (rvalid && rd_idx == cmc_pkg::IDX_MUX) |-> !rdata[cmc_pkg::BIT_MUX_RSV6])
    else $error("mux bit 6 read as one");
  chk_sync_path_delay: assert property (
    (mode == cmc_pkg::MODE_CONTINUOUS && !output_invert && cmp_active)[*4]
    |-> filtered_output_status == $past(i_comparator_raw, 3))
    else $error("continuous output does not follow raw result after sync");
  chk_rise_flag_set: assert property (
    $rose(filtered_output_status) |=> rise_edge_flag)
    else $error("rising edge missed");
  chk_fall_flag_set: assert property (
    $fell(filtered_output_status) |=> fall_edge_flag)
    else $error("falling edge missed");
  chk_flag_holds: assert property (
    (rise_edge_flag && !clr_rise) |=> rise_edge_flag)
    else $error("rise flag dropped without clear");
  chk_irq_gating: assert property (
    o_irq_req == ((rise_edge_flag && rise_irq_enable) || (fall_edge_flag && fall_irq_enable)))
    else $error("interrupt request does not match flags and enables");
  chk_disabled_out: assert property (
    (!enable)[*2] |-> filtered_output_status == $past(output_invert))
    else $error("disabled block output not at invert level");
  chk_filter_reset: assert property (
    (!sampling) |=> (filt_out == 1'b0 && agree_cnt == '0 && div_cnt == '0))
    else $error("filter state not cleared outside sampled modes");
  chk_filter_hold: assert property (
    (sampling && !sample_tick && $past(sampling)) |=> $stable(filt_out))
    else $error("filter output changed between samples");
endmodule : cmc_comparator_ctrl

//--- shared/cmc_pkg.sv
// constants for the comparator mux and mode control block
package cmc_pkg;
  // register indexes; the byte address is four times the index
  localparam logic [5:0] IDX_CTRL_COUNT = 6'h00;
  localparam logic [5:0] IDX_CTRL_MODE  = 6'h01;
  localparam logic [5:0] IDX_PERIOD     = 6'h02;
  localparam logic [5:0] IDX_STATUS     = 6'h03;
  localparam logic [5:0] IDX_MUX        = 6'h05;
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 3;
  localparam int PER_W  = 8;
  localparam int SEL_W  = 3;
  // mode register bits
  localparam int BIT_ENABLE = 0;
  localparam int BIT_INVERT = 1;
  localparam int BIT_SAMPLE = 2;
  localparam int BIT_WINDOW = 3;
  // status register bits
  localparam int BIT_FILTERED_OUTPUT_STATUS      = 0;
  localparam int BIT_FALL_FLAG = 1;
  localparam int BIT_RISE_FLAG = 2;
  localparam int BIT_FALL_IE   = 3;
  localparam int BIT_RISE_IE   = 4;
  // mux register fields
  localparam int PLUS_LSB     = 3;
  localparam int MINUS_LSB    = 0;
  localparam int BIT_MUX_RSV7 = 7;
  localparam int BIT_MUX_RSV6 = 6;
  // reset values and width-matched constants of one
  localparam logic [CNT_W-1:0] RST_COUNT  = 3'h0;
  localparam logic [PER_W-1:0] RST_PERIOD = 8'h00;
  localparam logic [7:0]       RST_MUX    = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 3'h1;
  localparam logic [PER_W-1:0] PER_ONE    = 8'h01;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    MODE_DISABLED,
    MODE_CONTINUOUS,
    MODE_SAMPLED,
    MODE_FILTERED,
    MODE_ILLEGAL
  } cmc_mode_type;
endpackage : cmc_pkg

//--- verification/cmc_analog_model.sv
// behavioural analog core: two eight-way selectors feeding one comparator
`timescale 1ns/1ns
module cmc_analog_model (
  input  wire logic [2:0] i_plus_sel,
  input  wire logic [2:0] i_minus_sel,
  input  wire logic       i_power,
  input  wire logic [7:0] i_level [8],
  output logic            o_raw
);
  // an unpowered core sits low, so a missed shut-down shows up as live data
  assign o_raw = i_power && (i_level[i_plus_sel] > i_level[i_minus_sel]);
endmodule : cmc_analog_model

//--- verification/tb_comparator_mux_mode_control.sv
// self-checking bench: register bus, input selection, modes, filter and edge flags
`timescale 1ns/1ns
module tb_comparator_mux_mode_control;
  logic        i_mclk;
  logic        i_rst_b;
  logic [7:0]  i_s_axi_awaddr;
  logic        i_s_axi_awvalid;
  logic [31:0] i_s_axi_wdata;
  logic [3:0]  i_s_axi_wstrb;
  logic        i_s_axi_wvalid;
  logic        i_s_axi_bready;
  logic [7:0]  i_s_axi_araddr;
  logic        i_s_axi_arvalid;
  logic        i_s_axi_rready;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata;
  logic [2:0]  o_noninverting_input, o_inverting_input;
  logic        o_comparator_power, o_comparator_result, o_irq_req, raw;
  logic [7:0]  lvl [8];
  logic [33:0] rq [$];
  logic [1:0]  bq [$];
  logic [33:0] exp_r;
  int          n_mismatch, compares, seed, lat, i;

  cmc_comparator_ctrl cmc_comparator_ctrl_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
    .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
    .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready), .i_comparator_raw(raw),
    .o_noninverting_input(o_noninverting_input), .o_inverting_input(o_inverting_input),
    .o_comparator_power(o_comparator_power), .o_comparator_result(o_comparator_result),
    .o_irq_req(o_irq_req)
  );
  cmc_analog_model cmc_analog_model_i (
    .i_plus_sel(o_noninverting_input), .i_minus_sel(o_inverting_input),
    .i_power(o_comparator_power), .i_level(lvl), .o_raw(raw)
  );

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic stop_test;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // a wait that ran out ends the run at once rather than cascading
  task automatic hang;
    n_mismatch++;
    stop_test();
  endtask : hang

  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask : end_test

  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] r);
    bit a;
    bit w;
    int n;
    a = 0;
    w = 0;
    bq.push_back(r);
    @(posedge i_mclk);
    i_s_axi_awaddr  <= {idx, 2'b00};
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wdata   <= d;
    i_s_axi_wvalid  <= 1'b1;
    i_s_axi_bready  <= 1'b1;
    for (n = 0; !(a && w); n++) begin
      @(posedge i_mclk);
      if (n > 50) hang();
      if (!a && o_s_axi_awready === 1'b1) begin
        a = 1;
        i_s_axi_awvalid <= 1'b0;
      end
      if (!w && o_s_axi_wready === 1'b1) begin
        w = 1;
        i_s_axi_wvalid <= 1'b0;
      end
    end
    for (n = 0; n <= 50 && o_s_axi_bvalid !== 1'b1; n++) @(posedge i_mclk);
    if (n > 50) hang();
    i_s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] r);
    int n;
    rq.push_back({r, e});
    @(posedge i_mclk);
    i_s_axi_araddr  <= {idx, 2'b00};
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready  <= 1'b1;
    for (n = 0; n <= 50; n++) begin
      @(posedge i_mclk);
      if (o_s_axi_arready === 1'b1) break;
    end
    if (n > 50) hang();
    i_s_axi_arvalid <= 1'b0;
    for (n = 0; n <= 50 && o_s_axi_rvalid !== 1'b1; n++) @(posedge i_mclk);
    if (n > 50) hang();
    i_s_axi_rready <= 1'b0;
  endtask : rd

  task automatic setlv(input int k, input logic [7:0] v);
    @(posedge i_mclk);
    lvl[k] <= v;
    repeat (5) @(posedge i_mclk);
  endtask : setlv

  // cycles from a rising plus input to the rising status output
  task automatic meas(input logic [2:0] c, input logic [7:0] p, output int l);
    wr(cmc_pkg::IDX_CTRL_COUNT, 32'h0, cmc_pkg::RESP_OKAY);
    wr(cmc_pkg::IDX_PERIOD, {24'h0, p}, cmc_pkg::RESP_OKAY);
    wr(cmc_pkg::IDX_CTRL_COUNT, {29'h0, c}, cmc_pkg::RESP_OKAY);
    repeat (40) @(posedge i_mclk);
    cmp(32'h0, {31'h0, o_comparator_result});
    @(posedge i_mclk);
    lvl[1] <= 8'hf0;
    // first look half a period on, so l counts the clock edges after the change
    @(negedge i_mclk);
    for (l = 0; l <= 200 && o_comparator_result !== 1'b1; l++) @(negedge i_mclk);
    if (l > 200) hang();
    @(posedge i_mclk);
    lvl[1] <= 8'h10;
    repeat (60) @(posedge i_mclk);
    wr(cmc_pkg::IDX_CTRL_COUNT, 32'h0, cmc_pkg::RESP_OKAY);
  endtask : meas

  always @(posedge i_mclk) begin
    if (o_s_axi_rvalid === 1'b1 && i_s_axi_rready === 1'b1) begin
      exp_r = rq.pop_front();
      cmp(exp_r[31:0], o_s_axi_rdata);
      cmp({30'h0, exp_r[33:32]}, {30'h0, o_s_axi_rresp});
    end
    if (o_s_axi_bvalid === 1'b1 && i_s_axi_bready === 1'b1)
      cmp({30'h0, bq.pop_front()}, {30'h0, o_s_axi_bresp});
  end

  initial begin
    seed = 54;
    {i_rst_b, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 4'h0;
    {i_s_axi_arvalid, i_s_axi_rready} = 2'h0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 48'h0;
    i_s_axi_wstrb = 4'hf;
    for (i = 0; i < 8; i++) lvl[i] = 8'h00;
    lvl[0] = 8'h80;
    lvl[1] = 8'h10;
    repeat (8) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    for (i = 0; i < 6; i++) if (i != 4) rd(6'(i), 32'h0, cmc_pkg::RESP_OKAY);
    rd(6'h04, 32'h0, cmc_pkg::RESP_SLVERR);
    wr(6'h06, 32'hff, cmc_pkg::RESP_SLVERR);
    rd(6'h06, 32'h0, cmc_pkg::RESP_SLVERR);
    cmp(32'h0, {31'h0, o_comparator_power});
    end_test("reset and map");
    for (i = 0; i < 8; i++) begin
      wr(cmc_pkg::IDX_MUX, 32'(32'h40 | (i << 3) | (7 - i)), cmc_pkg::RESP_OKAY);
      rd(cmc_pkg::IDX_MUX, 32'((i << 3) | (7 - i)), cmc_pkg::RESP_OKAY);
      cmp(32'(i), {29'h0, o_noninverting_input});
      cmp(32'(7 - i), {29'h0, o_inverting_input});
      cmp(32'h0, {31'h0, o_comparator_power});
    end
    end_test("input select");
    wr(cmc_pkg::IDX_MUX, 32'h09, cmc_pkg::RESP_OKAY);
    wr(cmc_pkg::IDX_CTRL_MODE, 32'h01, cmc_pkg::RESP_OKAY);
    cmp(32'h0, {31'h0, o_comparator_power});
    wr(cmc_pkg::IDX_MUX, 32'h08, cmc_pkg::RESP_OKAY);
    cmp(32'h1, {31'h0, o_comparator_power});
    meas(3'h0, 8'h00, lat);
    cmp(32'd3, 32'(lat));
    meas(3'h2, 8'h00, lat);
    cmp(32'd3, 32'(lat));
    meas(3'h0, 8'h05, lat);
    cmp(32'd3, 32'(lat));
    meas(3'h1, 8'h05, lat);
    cmp(32'h1, 32'(lat >= 2 && lat <= 9));
    meas(3'h3, 8'h04, lat);
    cmp(32'h1, 32'(lat >= 10 && lat <= 16));
    end_test("modes and filter");
    wr(cmc_pkg::IDX_STATUS, 32'h06, cmc_pkg::RESP_OKAY);
    rd(cmc_pkg::IDX_STATUS, 32'h00, cmc_pkg::RESP_OKAY);
    setlv(1, 8'hf0);
    rd(cmc_pkg::IDX_STATUS, 32'h05, cmc_pkg::RESP_OKAY);
    cmp(32'h0, {31'h0, o_irq_req});
    wr(cmc_pkg::IDX_STATUS, 32'h10, cmc_pkg::RESP_OKAY);
    cmp(32'h1, {31'h0, o_irq_req});
    wr(cmc_pkg::IDX_STATUS, 32'h14, cmc_pkg::RESP_OKAY);
    cmp(32'h0, {31'h0, o_irq_req});
    rd(cmc_pkg::IDX_STATUS, 32'h11, cmc_pkg::RESP_OKAY);
    setlv(1, 8'h10);
    rd(cmc_pkg::IDX_STATUS, 32'h12, cmc_pkg::RESP_OKAY);
    cmp(32'h0, {31'h0, o_irq_req});
    wr(cmc_pkg::IDX_STATUS, 32'h08, cmc_pkg::RESP_OKAY);
    cmp(32'h1, {31'h0, o_irq_req});
    wr(cmc_pkg::IDX_CTRL_MODE, 32'h03, cmc_pkg::RESP_OKAY);
    repeat (5) @(posedge i_mclk);
    rd(cmc_pkg::IDX_STATUS, 32'h0f, cmc_pkg::RESP_OKAY);
    wr(cmc_pkg::IDX_CTRL_MODE, 32'h02, cmc_pkg::RESP_OKAY);
    cmp(32'h0, {31'h0, o_comparator_power});
    repeat (5) @(posedge i_mclk);
    rd(cmc_pkg::IDX_STATUS, 32'h0f, cmc_pkg::RESP_OKAY);
    wr(cmc_pkg::IDX_STATUS, 32'h06, cmc_pkg::RESP_OKAY);
    rd(cmc_pkg::IDX_STATUS, 32'h01, cmc_pkg::RESP_OKAY);
    end_test("edge flags");
    wr(cmc_pkg::IDX_CTRL_MODE, 32'h01, cmc_pkg::RESP_OKAY);
    wr(cmc_pkg::IDX_MUX, 32'h15, cmc_pkg::RESP_OKAY);
    for (i = 0; i < 12; i++) begin
      @(posedge i_mclk);
      lvl[2] <= 8'($random(seed));
      lvl[5] <= 8'($random(seed));
      repeat (5) @(posedge i_mclk);
      cmp({31'h0, lvl[2] > lvl[5]}, {31'h0, o_comparator_result});
    end
    end_test("random levels");
    stop_test();
  end
endmodule : tb_comparator_mux_mode_control
